// ===== hw/smcg_pkg.sv
// Package: sleep mode encodings and clock enable layout
package smcg_pkg;

  typedef enum logic [2:0] {
    SMCG_IDLE    = 3'h0,
    SMCG_ADCNR   = 3'h1,
    SMCG_PDOWN   = 3'h2,
    SMCG_PSAVE   = 3'h3,
    SMCG_STBY    = 3'h6,
    SMCG_XSTBY   = 3'h7
  } smcg_mode_t;

  typedef enum logic [1:0] {
    SMCG_ST_RUN   = 2'h0,
    SMCG_ST_ENTER = 2'h1,
    SMCG_ST_SLEEP = 2'h3
  } smcg_state_t;

  // One enable per clock domain / function group
  typedef struct packed {
    logic cpu;
    logic mem;
    logic io;
    logic adc;
    logic osc;
    logic async_tmr;
  } smcg_en_t;

  localparam smcg_en_t SMCG_EN_ALL = 6'h3f;
  localparam smcg_en_t SMCG_EN_RST = 6'h3f;

  // Synchroniser depth for the pin-side wake request
  localparam int SMCG_SYNC_STAGES = 2;

endpackage : smcg_pkg

// ===== hw/smcg_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module smcg_sync
  import smcg_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             mclk,   // System clock
  input  wire logic             rst,    // Sync reset, active high
  input  wire logic [WIDTH-1:0] d_in,   // Asynchronous level
  output logic      [WIDTH-1:0] q_out   // Synchronised level
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Build-time guard on the width
  if (WIDTH < 1)
  begin : g_width_chk
    $error("Synchroniser needs a width of at least one");
  end

  always_comb
  begin
    meta_d = d_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_out = sync_q;

endmodule : smcg_sync
`default_nettype wire

// ===== hw/smcg_ctrl.sv
// Sleep mode controller: per-domain clock enables for six sleep modes
//
// Summary of operation
// - Software picks one of six sleep modes: idle, converter noise cut, power-save, power-down, standby, extended standby.
// - Idle stops the core while memory, timers, serial port and interrupts run on.
// - Power-down keeps register state, stops the oscillator and all else until interrupt or reset.
// - Power-save keeps only the asynchronous timer running.
// - Converter noise cut stops core and all I/O except the asynchronous timer and converter.
// - Standby keeps the main oscillator running while everything else sleeps.
// - Extended standby keeps the main oscillator and the asynchronous timer running.
`timescale 1ns/10ps
`default_nettype none
module smcg_ctrl
  import smcg_pkg::*;
(
  input  wire logic       mclk,        // 200 MHz system clock
  input  wire logic       rst,         // Sync reset, active high
  input  wire logic       sleep_req,   // Core sleep instruction, pulse
  input  wire logic       sleep_en,    // Sleep permitted
  input  wire logic [2:0] sleep_mode,  // Requested mode code
  input  wire logic       irq_int,     // Enabled internal interrupt
  input  wire logic       irq_pin,     // Asynchronous wake interrupt pin
  output smcg_en_t        clk_en,      // Per-domain clock enables
  output logic            asleep,      // Device in a sleep mode
  output smcg_mode_t      mode_act,    // Mode being held
  output logic            wake_pulse   // One cycle on wake-up
);

  logic        irq_pin_s;
  logic        wake;
  logic        mode_ok;
  smcg_state_t st_q;
  smcg_state_t st_d;
  smcg_mode_t  mode_q;
  smcg_mode_t  mode_d;
  smcg_en_t    en_q;
  smcg_en_t    en_d;
  smcg_en_t    sleep_map;
  logic        wake_q;
  logic        wake_d;

  smcg_sync #(
    .WIDTH (1)
  ) u_irq_sync (
    .mclk  (mclk),
    .rst   (rst),
    .d_in  (irq_pin),
    .q_out (irq_pin_s)
  );

  assign wake = irq_int | irq_pin_s;

  // Build-time guards on the shared constants
  if (SMCG_SYNC_STAGES != 2)
  begin : g_sync_depth_chk
    $error("Wake synchroniser is built with two stages only");
  end
  if (SMCG_EN_RST != SMCG_EN_ALL)
  begin : g_rst_map_chk
    $error("Reset must leave every domain enabled");
  end

  // Legal mode codes only
  always_comb
  begin
    unique case (sleep_mode)
      SMCG_IDLE, SMCG_ADCNR, SMCG_PDOWN,
      SMCG_PSAVE, SMCG_STBY, SMCG_XSTBY: mode_ok = 1'b1;
      default:                           mode_ok = 1'b0;
    endcase
  end

  // Enables held in each sleep mode, every domain spelled out
  always_comb
  begin
    sleep_map = SMCG_EN_ALL;
    unique case (mode_q)
      SMCG_IDLE:
      begin
        sleep_map.cpu       = 1'b0;
        sleep_map.mem       = 1'b1;
        sleep_map.io        = 1'b1;
        sleep_map.adc       = 1'b1;
        sleep_map.osc       = 1'b1;
        sleep_map.async_tmr = 1'b1;
      end
      SMCG_ADCNR:
      begin
        sleep_map.cpu       = 1'b0;
        sleep_map.mem       = 1'b1;
        sleep_map.io        = 1'b0;
        sleep_map.adc       = 1'b1;
        sleep_map.osc       = 1'b1;
        sleep_map.async_tmr = 1'b1;
      end
      SMCG_PDOWN:
      begin
        sleep_map.cpu       = 1'b0;
        sleep_map.mem       = 1'b0;
        sleep_map.io        = 1'b0;
        sleep_map.adc       = 1'b0;
        sleep_map.osc       = 1'b0;
        sleep_map.async_tmr = 1'b0;
      end
      SMCG_PSAVE:
      begin
        sleep_map.cpu       = 1'b0;
        sleep_map.mem       = 1'b0;
        sleep_map.io        = 1'b0;
        sleep_map.adc       = 1'b0;
        sleep_map.osc       = 1'b0;
        sleep_map.async_tmr = 1'b1;
      end
      SMCG_STBY:
      begin
        sleep_map.cpu       = 1'b0;
        sleep_map.mem       = 1'b0;
        sleep_map.io        = 1'b0;
        sleep_map.adc       = 1'b0;
        sleep_map.osc       = 1'b1;
        sleep_map.async_tmr = 1'b0;
      end
      SMCG_XSTBY:
      begin
        sleep_map.cpu       = 1'b0;
        sleep_map.mem       = 1'b0;
        sleep_map.io        = 1'b0;
        sleep_map.adc       = 1'b0;
        sleep_map.osc       = 1'b1;
        sleep_map.async_tmr = 1'b1;
      end
      default:
        sleep_map = SMCG_EN_ALL;
    endcase
  end

  // Sleep state and held mode
  always_comb
  begin
    st_d   = st_q;
    mode_d = mode_q;
    unique case (st_q)
      SMCG_ST_RUN:
      begin
        if (sleep_req && sleep_en && mode_ok && !wake)
        begin
          mode_d = smcg_mode_t'(sleep_mode);
          st_d   = SMCG_ST_ENTER;
        end
      end
      SMCG_ST_ENTER:
      begin
        if (wake)
          st_d = SMCG_ST_RUN;
        else
          st_d = SMCG_ST_SLEEP;
      end
      SMCG_ST_SLEEP:
      begin
        if (wake)
          st_d = SMCG_ST_RUN;
      end
      default:
        st_d = SMCG_ST_RUN;
    endcase
  end

  // Domain enables and wake strobe; a wake during entry drops no clock
  always_comb
  begin
    en_d   = en_q;
    wake_d = 1'b0;
    unique case (st_q)
      SMCG_ST_RUN:
        en_d = SMCG_EN_ALL;
      SMCG_ST_ENTER,
      SMCG_ST_SLEEP:
      begin
        if (wake)
        begin
          en_d   = SMCG_EN_ALL;
          wake_d = 1'b1;
        end
        else
        begin
          en_d = sleep_map;
        end
      end
      default:
        en_d = SMCG_EN_ALL;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q   <= SMCG_ST_RUN;
      mode_q <= SMCG_IDLE;
    end
    else
    begin
      st_q   <= st_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      en_q   <= SMCG_EN_RST;
      wake_q <= 1'b0;
    end
    else
    begin
      en_q   <= en_d;
      wake_q <= wake_d;
    end
  end

  assign clk_en     = en_q;
  assign asleep     = (st_q == SMCG_ST_SLEEP);
  assign mode_act   = mode_q;
  assign wake_pulse = wake_q;

endmodule : smcg_ctrl
`default_nettype wire

// ===== sim/smcg_asserts.sv
// Checker for the sleep mode controller
`timescale 1ns/10ps
`default_nettype none
module smcg_asserts
  import smcg_pkg::*;
(
  input wire logic       mclk,       // clock
  input wire logic       rst,        // reset
  input wire logic       sleep_req,  // request
  input wire logic       sleep_en,   // permit
  input wire logic [2:0] sleep_mode, // mode
  input wire logic       irq_int,    // wake
  input wire logic       irq_pin,    // pin wake
  input wire smcg_en_t   clk_en,     // enables
  input wire logic       asleep,     // sleeping
  input wire smcg_mode_t mode_act,   // held mode
  input wire logic       wake_pulse  // wake strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  idle_map_a: assert property
    (asleep && mode_act == SMCG_IDLE |-> clk_en == 6'h1f) else $error("idle");
  pdown_map_a: assert property
    (asleep && mode_act == SMCG_PDOWN |-> clk_en == 6'h00) else $error("pd");
  psave_map_a: assert property
    (asleep && mode_act == SMCG_PSAVE |-> clk_en == 6'h01) else $error("ps");
  adcnr_map_a: assert property
    (asleep && mode_act == SMCG_ADCNR |-> clk_en == 6'h17) else $error("nr");
  stby_map_a: assert property
    (asleep && mode_act == SMCG_STBY |-> clk_en == 6'h02) else $error("sb");
  xstby_map_a: assert property
    (asleep && mode_act == SMCG_XSTBY |-> clk_en == 6'h03) else $error("xs");
  wake_exit_a: assert property
    (asleep && irq_int |=> !asleep && wake_pulse && clk_en == 6'h3f)
    else $error("wake");
  pulse_once_a: assert property
    (wake_pulse |=> !wake_pulse) else $error("pulse");
  pin_wake_a: assert property
    (irq_pin [*3] |=> !asleep) else $error("pin");
  entry_cause_a: assert property
    ($rose(asleep) |-> $past(sleep_req, 2) || $past(sleep_req, 3))
    else $error("entry");
endmodule : smcg_asserts
bind smcg_ctrl smcg_asserts u_chk (.mclk(mclk), .rst(rst),
  .sleep_req(sleep_req), .sleep_en(sleep_en), .sleep_mode(sleep_mode),
  .irq_int(irq_int), .irq_pin(irq_pin), .clk_en(clk_en), .asleep(asleep),
  .mode_act(mode_act), .wake_pulse(wake_pulse));
`default_nettype wire

// ===== sim/tb_top.sv
// Testbench for the sleep mode controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import smcg_pkg::*;
  logic       mclk = 0, rst = 1, sleep_req = 0, sleep_en = 1;
  logic       irq_int = 0, irq_pin = 0, asleep, wake_pulse;
  logic [2:0] sleep_mode = 3'h0;
  smcg_en_t   clk_en;
  smcg_mode_t mode_act;
  int         mismatches = 0, compares = 0;
  always #2.5 mclk = ~mclk;
  smcg_ctrl DUT (.mclk(mclk), .rst(rst), .sleep_req(sleep_req),
    .sleep_en(sleep_en), .sleep_mode(sleep_mode), .irq_int(irq_int),
    .irq_pin(irq_pin), .clk_en(clk_en), .asleep(asleep),
    .mode_act(mode_act), .wake_pulse(wake_pulse));
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic enter(input logic [2:0] m);
    @(negedge mclk);
    sleep_mode = m;
    sleep_req = 1;
    @(negedge mclk);
    sleep_req = 0;
    repeat (3) @(negedge mclk);
  endtask : enter
  task automatic t_modes;
    logic [2:0] md[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [5:0] mp[6] = '{6'h1f, 6'h17, 6'h00, 6'h01, 6'h02, 6'h03};
    chk({asleep, clk_en[4:0]}, 6'h1f);
    chk({wake_pulse, 2'h0, mode_act}, 6'h00);
    for (int i = 0; i < 6; i++)
    begin
      enter(md[i]);
      chk(clk_en, mp[i]);
      chk({3'h0, mode_act}, {3'h0, md[i]});
      irq_int = 1;
      @(negedge mclk);
      irq_int = 0;
      chk({wake_pulse, asleep, clk_en[3:0]}, 6'h2f);
    end
    $display("modes test done");
  endtask : t_modes
  task automatic t_refuse;
    logic [2:0] bad[3] = '{3'h4, 3'h5, 3'h2};
    for (int i = 0; i < 3; i++)
    begin
      sleep_en = (i < 2);
      enter(bad[i]);
      chk({asleep, clk_en[4:0]}, 6'h1f);
      chk({3'h0, mode_act}, 6'h07);
    end
    sleep_en = 1;
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_pin;
    enter(3'h2);
    chk(clk_en, 6'h00);
    sleep_mode = 3'h7;
    sleep_req = 1;
    @(negedge mclk);
    sleep_req = 0;
    @(negedge mclk);
    chk({3'h0, mode_act}, 6'h02);
    chk(clk_en, 6'h00);
    irq_pin = 1;
    repeat (5) @(negedge mclk);
    irq_pin = 0;
    chk({asleep, clk_en[4:0]}, 6'h1f);
    repeat (4) @(negedge mclk);
    $display("pin wake test done");
  endtask : t_pin
  task automatic t_rst;
    enter(3'h3);
    chk(clk_en, 6'h01);
    rst = 1;
    @(negedge mclk);
    rst = 0;
    chk({asleep, clk_en[4:0]}, 6'h1f);
    chk({wake_pulse, 2'h0, mode_act}, 6'h00);
    $display("reset wake test done");
  endtask : t_rst
  task automatic t_enter_wake;
    @(negedge mclk);
    sleep_mode = 3'h3;
    sleep_req = 1;
    @(negedge mclk);
    sleep_req = 0;
    irq_int = 1;
    @(negedge mclk);
    irq_int = 0;
    chk(clk_en, 6'h3f);
    chk({wake_pulse, asleep, 4'h0}, 6'h20);
    @(negedge mclk);
    chk({wake_pulse, asleep, clk_en[3:0]}, 6'h0f);
    $display("entry wake test done");
  endtask : t_enter_wake
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (8) @(negedge mclk);
    rst = 0;
    t_modes;
    t_refuse;
    t_enter_wake;
    t_pin;
    t_rst;
    close_out;
  end
  initial
  begin
    #5000;
    mismatches++;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
